// ==== design/adc_fmt_pkg.sv ====
/*
 * Shared constants and carrier types for the converter output formatter.
 * Assumes one 200 MHz sample clock and a converter core that hands over
 * a raw two's-complement result and range comparator flags every cycle.
 */
// What this block does
// - each result leaves as a 12-bit word, msb is bit 11, true and complement
// - out-of-range sample raises the true range flag with its own word
// - out-of-range sample drops the complementary range flag, pair stays differential
// - format select 0 gives two's complement, 1 gives offset binary
// - format select has no pull-down; tie it low for two's complement
// - a forwarded capture clock pair derived from the sample clock accompanies the data
// - each word appears eleven clock cycles after its sampling edge unless the pipe stalls for a launch cycle or a full buffer
// - at half rate, words are launched so the receiver latches on the next capture clock rise; at full rate they can change every cycle
// - out-of-range means above positive or below negative full scale
// - rate select 0 updates outputs at half rate, 1 at full rate
package adc_fmt_pkg;

	localparam int          WORD_W         = 12;
	localparam int          MSB_BIT        = 11;
	localparam int          LATENCY_CYCLES = 11;
	// one cycle is spent in the output buffer head, the rest in the pipe
	localparam int          PIPE_STAGES    = LATENCY_CYCLES - 1;
	localparam logic [11:0] WORD_RESET     = 12'h000;

	// output word with its range flag
	typedef struct packed {
		logic              range;
		logic [WORD_W-1:0] code;
	} coded_word_t;

	// one pipeline slot
	typedef struct packed {
		logic        valid;
		coded_word_t word;
	} pipe_stage_t;

	// phase of the forwarded capture clock, gray along the toggle path
	typedef enum logic {
		PH_LOW  = 1'b0,
		PH_HIGH = 1'b1
	} clock_phase_t;

	localparam pipe_stage_t STAGE_RESET = '{valid: 1'b0, word: '{range: 1'b0, code: WORD_RESET}};

endpackage : adc_fmt_pkg

// ==== design/word_skid_buffer.sv ====
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes a synchronous active-high reset and a single clock.
 */
`timescale 1ns/100ps
module word_skid_buffer #(
	parameter int WIDTH = 13
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// filling side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// draining side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);

	typedef struct packed {
		logic             head_v;
		logic             skid_v;
		logic [WIDTH-1:0] head;
		logic [WIDTH-1:0] skid;
	} skid_state_t;

	skid_state_t state_reg;
	skid_state_t state_next;
	logic        push;
	logic        pop;

	// ready only while the second slot is free, so a stall loses nothing
	assign in_ready_out  = !state_reg.skid_v;
	assign out_valid_out = state_reg.head_v;
	assign out_data_out  = state_reg.head;
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_ready_in && state_reg.head_v;

	// pop refills head from skid first, then a push lands in the free slot
	always_comb begin
		state_next = state_reg;
		if (pop) begin
			state_next.head   = state_reg.skid;
			state_next.head_v = state_reg.skid_v;
			state_next.skid_v = 1'b0;
		end
		if (push) begin
			if (!state_next.head_v) begin
				state_next.head   = in_data_in;
				state_next.head_v = 1'b1;
			end else begin
				state_next.skid   = in_data_in;
				state_next.skid_v = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule : word_skid_buffer

// ==== design/adc_output_formatter.sv ====
/*
 * Digital output stage of a 12-bit pipelined converter: coding, range flag,
 * stallable fixed-length pipe, two-entry output buffer and forwarded capture clock.
 * Assumes the converter core presents a saturated two's-complement result and
 * range comparator flags synchronous to clk_in; the strap inputs are static.
 */
`timescale 1ns/100ps
module adc_output_formatter (
	// clock and reset
	input  wire logic                              clk_in,
	input  wire logic                              rst_in,
	// raw result from the converter core
	input  wire logic                              sample_valid_in,
	input  wire logic [adc_fmt_pkg::WORD_W-1:0]    sample_in,
	input  wire logic                              above_full_scale_in,
	input  wire logic                              below_full_scale_in,
	output logic                                   sample_ready_out,
	// straps, tie low when unused
	input  wire logic                              format_select_in,
	input  wire logic                              rate_halving_select_in,
	// data pairs to the receiver
	output logic [adc_fmt_pkg::WORD_W-1:0]         word_true_out,
	output logic [adc_fmt_pkg::WORD_W-1:0]         word_comp_out,
	output logic                                   range_flag_true_out,
	output logic                                   range_flag_comp_out,
	output logic                                   capture_valid_out,
	input  wire logic                              capture_ready_in,
	// forwarded capture clock pair
	output logic                                   capture_clock_true_out,
	output logic                                   capture_clock_comp_out
);

	typedef struct packed {
		adc_fmt_pkg::clock_phase_t                            phase;
		adc_fmt_pkg::pipe_stage_t [adc_fmt_pkg::PIPE_STAGES-1:0] pipe;
	} fmt_state_t;

	fmt_state_t               state_reg;
	fmt_state_t               state_next;
	adc_fmt_pkg::coded_word_t coded;
	adc_fmt_pkg::coded_word_t head_word;
	logic                     buf_in_ready;
	logic                     launch;
	logic                     accepted;
	logic                     advance;

	// two's complement to the selected coding, only the msb may flip
	function automatic logic [adc_fmt_pkg::WORD_W-1:0] code_word(
		input logic [adc_fmt_pkg::WORD_W-1:0] raw,
		input logic                           offset_binary
	);
		logic [adc_fmt_pkg::WORD_W-1:0] res;
		res                       = raw;
		res[adc_fmt_pkg::MSB_BIT] = raw[adc_fmt_pkg::MSB_BIT] ^ offset_binary;
		return res;
	endfunction : code_word

	// coding and range decision at the pipe entry
	always_comb begin
		coded.code  = code_word(sample_in, format_select_in == 1'b1);
		coded.range = above_full_scale_in || below_full_scale_in;
	end

	// pipe stalls when the buffer is full, or when its last word must wait for a
	// launch cycle; buffer then only changes on launch edges, so half-rate words
	// never move while the capture clock is high
	assign advance          = buf_in_ready
		&& (launch || !state_reg.pipe[adc_fmt_pkg::PIPE_STAGES-1].valid);
	assign sample_ready_out = advance;
	assign accepted         = sample_valid_in && advance;

	// at half rate words leave when the clock is about to fall, so they are settled at its next rise; full rate launches every cycle
	assign launch = rate_halving_select_in || (state_reg.phase == adc_fmt_pkg::PH_HIGH);

	// phase toggle and fixed-length pipe
	always_comb begin
		state_next = state_reg;
		case (state_reg.phase)
			adc_fmt_pkg::PH_LOW:  state_next.phase = adc_fmt_pkg::PH_HIGH;
			adc_fmt_pkg::PH_HIGH: state_next.phase = adc_fmt_pkg::PH_LOW;
			default:              state_next.phase = adc_fmt_pkg::PH_LOW;
		endcase
		if (advance) begin
			state_next.pipe[0].valid = accepted;
			state_next.pipe[0].word  = coded;
			for (int i = 1; i < adc_fmt_pkg::PIPE_STAGES; i++) begin
				state_next.pipe[i] = state_reg.pipe[i-1];
			end
		end
	end

	// state register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg.phase <= adc_fmt_pkg::PH_LOW;
			state_reg.pipe  <= {adc_fmt_pkg::PIPE_STAGES{adc_fmt_pkg::STAGE_RESET}};
		end else begin
			state_reg <= state_next;
		end
	end

	// last pipe slot feeds the buffer; head register is the eleventh stage
	word_skid_buffer #(
		.WIDTH ($bits(adc_fmt_pkg::coded_word_t))
	) out_buffer (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (state_reg.pipe[adc_fmt_pkg::PIPE_STAGES-1].valid && launch),
		.in_ready_out  (buf_in_ready),
		.in_data_in    (state_reg.pipe[adc_fmt_pkg::PIPE_STAGES-1].word),
		.out_valid_out (capture_valid_out),
		.out_ready_in  (capture_ready_in && launch),
		.out_data_out  (head_word)
	);

	// differential pairs, complement is the exact inverse of the true leg
	assign word_true_out          = head_word.code;
	assign word_comp_out          = ~head_word.code;
	assign range_flag_true_out    = head_word.range;
	assign range_flag_comp_out    = !head_word.range;
	assign capture_clock_true_out = (state_reg.phase == adc_fmt_pkg::PH_HIGH);
	assign capture_clock_comp_out = (state_reg.phase != adc_fmt_pkg::PH_HIGH);

	property p_word_pair;
		@(posedge clk_in) disable iff (rst_in)
		word_comp_out == ~word_true_out;
	endproperty
	a_word_pair: assert property (p_word_pair)
		else $error("word complement leg does not mirror true leg");

	property p_range_pair;
		@(posedge clk_in) disable iff (rst_in)
		range_flag_true_out |-> !range_flag_comp_out;
	endproperty
	a_range_pair: assert property (p_range_pair)
		else $error("range flag pair not differential");

	property p_coding;
		@(posedge clk_in) disable iff (rst_in)
		accepted |=> state_reg.pipe[0].word.code[10:0] == $past(sample_in[10:0])
			&& state_reg.pipe[0].word.code[11] == ($past(sample_in[11]) ^ $past(format_select_in));
	endproperty
	a_coding: assert property (p_coding)
		else $error("output coding does not follow format select");

	property p_range_cause;
		@(posedge clk_in) disable iff (rst_in)
		accepted |=> state_reg.pipe[0].word.range
			== ($past(above_full_scale_in) || $past(below_full_scale_in));
	endproperty
	a_range_cause: assert property (p_range_cause)
		else $error("range flag does not match full scale comparators");

	property p_clock_toggles;
		@(posedge clk_in) disable iff (rst_in)
		capture_clock_true_out |=> !capture_clock_true_out ##1 capture_clock_true_out;
	endproperty
	a_clock_toggles: assert property (p_clock_toggles)
		else $error("capture clock stopped toggling");

	property p_launch_edge;
		@(posedge clk_in) disable iff (rst_in)
		(!rate_halving_select_in && $changed(word_true_out)) |-> !capture_clock_true_out;
	endproperty
	a_launch_edge: assert property (p_launch_edge)
		else $error("half-rate word changed while capture clock high");

	property p_half_rate;
		@(posedge clk_in) disable iff (rst_in)
		(!rate_halving_select_in && $changed(word_true_out)) |=> $stable(word_true_out);
	endproperty
	a_half_rate: assert property (p_half_rate)
		else $error("half-rate word held for only one cycle");

	property p_latency;
		@(posedge clk_in) disable iff (rst_in)
		accepted ##1 sample_ready_out[*8] ##1 sample_ready_out |=>
			state_reg.pipe[adc_fmt_pkg::PIPE_STAGES-1].valid
			&& state_reg.pipe[adc_fmt_pkg::PIPE_STAGES-1].word.code == $past(coded.code, 10);
	endproperty
	a_latency: assert property (p_latency)
		else $error("pipe latency to buffer entry is not ten cycles");

endmodule : adc_output_formatter

// ==== dv/capture_receiver_model.sv ====
/*
 * Receiver model at the far side of the formatter's parallel output.
 * Assumes the formatter's launch cycles: full rate, or capture clock high.
 */
`timescale 1ns/100ps
module capture_receiver_model (
	// clock, reset and strap
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        rate_in,
	input  wire logic [6:0]  stall_pct_in,
	// data from the formatter
	input  wire logic [11:0] word_in,
	input  wire logic        range_in,
	input  wire logic        valid_in,
	input  wire logic        clock_in,
	output logic             ready_out,
	// captured word
	output logic             got_out,
	output logic [11:0]      got_word_out,
	output logic             got_range_out,
	output logic             got_clock_out
);
	// random stalls fill the buffer; a word is latched on a launch edge only
	always @(posedge clk_in) begin
		ready_out <= !rst_in && (($urandom % 100) >= 32'(stall_pct_in));
		got_out <= valid_in && ready_out && (rate_in || clock_in);
		got_word_out <= word_in;
		got_range_out <= range_in;
		got_clock_out <= clock_in;
	end
endmodule : capture_receiver_model

// ==== dv/adc_output_formatter_tb.sv ====
/*
 * Self-checking bench of the output formatter with a receiver model.
 * Assumes the straps change only while reset is held.
 */
`timescale 1ns/100ps
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin err_count++; \
	$display("FAIL %0t %s", $time, m); end end
module adc_output_formatter_tb;
	logic clk_in, rst_in, sample_valid_in, above_in, below_in, fmt_in, rate_in;
	logic        ready_in, sample_ready_out, cap_valid, clk_t, clk_c, rng_t, rng_c;
	logic        got, got_rng, got_clk, rst_d, prev_clk, saw_refuse, saw_b2b;
	logic [11:0] sample_in, word_t, word_c, got_word;
	logic [6:0]  stall;
	logic [12:0] exp_q[$];
	logic [12:0] e;
	int          err_count, checks_done, cycles, last_got;
	adc_output_formatter dut (.clk_in(clk_in), .rst_in(rst_in),
		.sample_valid_in(sample_valid_in), .sample_in(sample_in),
		.above_full_scale_in(above_in), .below_full_scale_in(below_in),
		.sample_ready_out(sample_ready_out), .format_select_in(fmt_in),
		.rate_halving_select_in(rate_in), .word_true_out(word_t), .word_comp_out(word_c),
		.range_flag_true_out(rng_t), .range_flag_comp_out(rng_c),
		.capture_valid_out(cap_valid), .capture_ready_in(ready_in),
		.capture_clock_true_out(clk_t), .capture_clock_comp_out(clk_c));
	capture_receiver_model rx (.clk_in(clk_in), .rst_in(rst_in), .rate_in(rate_in),
		.stall_pct_in(stall), .word_in(word_t), .range_in(rng_t), .valid_in(cap_valid),
		.clock_in(clk_t), .ready_out(ready_in), .got_out(got), .got_word_out(got_word),
		.got_range_out(got_rng), .got_clock_out(got_clk));
	initial begin
		clk_in = 0;
		forever #2.5 clk_in = ~clk_in;
	end
	// note each taken sample: msb flipped for offset binary, flag from either comparator
	always @(posedge clk_in) begin
		if (sample_valid_in && sample_ready_out)
			exp_q.push_back({above_in | below_in, sample_in ^ {fmt_in, 11'h000}});
		if (!sample_ready_out)
			saw_refuse <= 1;
	end
	// watcher: oldest note against each captured word, and pairs every cycle once reset is low now and one cycle back
	always @(posedge clk_in) begin
		cycles++;
		rst_d <= rst_in;
		prev_clk <= clk_t;
		if (got) begin
			e = exp_q.pop_front();
			`CHK(got_word, e[11:0], "word")
			`CHK(got_rng, e[12], "range flag")
			if (!rate_in) `CHK(got_clk, 1'b1, "half rate launch")
			if (rate_in && cycles - last_got == 1) saw_b2b <= 1;
			last_got = cycles;
		end
		if (!rst_in && !rst_d) begin
			`CHK(word_c, ~word_t, "word pair")
			`CHK(rng_c, ~rng_t, "range pair")
			`CHK({clk_c, clk_t}, {prev_clk, ~prev_clk}, "capture clock")
		end
		if (cycles == 30000) begin
			err_count++;
			$display("FAIL %0t timeout", $time);
			close_out();
		end
	end
	task automatic send(input int n);
		int k;
		for (int i = 0; i < n; i++) begin
			k = $urandom % 8;
			sample_valid_in <= 1;
			above_in <= (k == 0);
			below_in <= (k == 1);
			sample_in <= (k == 0) ? 12'h7FF : (k == 1) ? 12'h800 : 12'($urandom);
			do @(posedge clk_in); while (sample_ready_out !== 1'b1);
		end
		sample_valid_in <= 0;
	endtask : send
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	initial begin
		int n;
		{rst_in, sample_valid_in, above_in, below_in, fmt_in, rate_in} = 6'h20;
		{sample_in, stall, saw_refuse, saw_b2b, last_got} = 0;
		void'($urandom(31));
		for (int c = 0; c < 8; c++) begin
			// straps set under reset; fmt 0 is the tied-low setting
			rst_in <= 1;
			fmt_in <= c[0];
			rate_in <= c[1];
			stall <= c[2] ? 7'h3C : 7'h00;
			repeat (12) @(posedge clk_in);
			rst_in <= 0;
			@(posedge clk_in);
			`CHK({word_t, word_c, rng_t, rng_c, cap_valid, clk_t, clk_c, sample_ready_out},
				{12'h000, 12'hFFF, 6'h13}, "reset state")
			send(1);
			n = 0;
			do begin
				@(posedge clk_in);
				n++;
			end while (cap_valid !== 1'b1 && n < 40);
			`CHK(n, adc_fmt_pkg::LATENCY_CYCLES, "latency")
			send(60);
			n = 0;
			while ((exp_q.size() != 0 || cap_valid !== 1'b0) && n < 2000) begin
				@(posedge clk_in);
				n++;
			end
			`CHK(exp_q.size(), 0, "drain")
			$display("test %0d done", c);
		end
		`CHK(saw_refuse, 1'b1, "buffer full refusal")
		`CHK(saw_b2b, 1'b1, "full rate back to back")
		close_out();
	end
endmodule : adc_output_formatter_tb
